// ---- logic/qti_map.svh ----
// register offsets, field positions, reset values and trim constants
`ifndef QTI_MAP_SVH
`define QTI_MAP_SVH

// ---------------------------------------------------------------
// register offsets (word index on the control port)
// ---------------------------------------------------------------
`define QTI_OFS_STATUS        4'h1
`define QTI_OFS_CH2_OFFSET    4'ha
`define QTI_OFS_CH2_FULLSCALE 4'hb
`define QTI_OFS_INTERLEAVE    4'hd

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define QTI_RST_CH2_OFFSET    16'h007f
`define QTI_RST_CH2_FULLSCALE 16'h807f
`define QTI_RST_INTERLEAVE    16'h3fff
`define QTI_RST_FS_CODE       9'h100
`define QTI_RST_FS_MV         10'h2bc

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define QTI_OFS_MAG_HI        15
`define QTI_OFS_MAG_LO        8
`define QTI_OFS_SIGN_BIT      7
`define QTI_FS_HI             15
`define QTI_FS_LO             7
`define QTI_TRIM_PAD_MASK     16'h007f
`define QTI_IL_ENABLE_BIT     15
`define QTI_IL_AUTO_BIT       14
`define QTI_IL_PAD_MASK       16'h3fff

// ---------------------------------------------------------------
// status bit positions
// ---------------------------------------------------------------
`define QTI_ST_INTERLEAVE     0
`define QTI_ST_AUTO_PHASE     1
`define QTI_ST_LOCKED         2
`define QTI_ST_PAD_ERROR      3
`define QTI_ST_FS_WIDE        4

// ---------------------------------------------------------------
// analog trim scale
// ---------------------------------------------------------------
`define QTI_OFFSET_FULL_UV    45000
`define QTI_OFFSET_MAX_CODE   255
`define QTI_FS_MIN_MV         560
`define QTI_FS_SPAN_MV        280
`define QTI_FS_MAX_CODE       511
`define QTI_FS_REC_LO         9'h0c0
`define QTI_FS_REC_HI         9'h1c0

// ---------------------------------------------------------------
// phase tracking
// ---------------------------------------------------------------
`define QTI_LOCK_CYCLES       16
`define QTI_DELAY_MID         8'h80

`endif

// ---- logic/qti_pkg.sv ----
// types shared by the trim and interleave register bank
package qti_pkg;

   typedef struct packed {
      logic [7:0] magnitude;
      logic       negative;
   } qti_offset_s;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } qti_bus_s;

   typedef enum logic [1:0] {
      QTI_MODE_DUAL       = 2'b01,
      QTI_MODE_INTERLEAVE = 2'b10
   } qti_mode_e;

   typedef enum logic [2:0] {
      QTI_PH_MANUAL  = 3'b001,
      QTI_PH_ACQUIRE = 3'b010,
      QTI_PH_LOCKED  = 3'b100
   } qti_phase_e;

endpackage : qti_pkg

// ---- logic/qti_phase_track.sv ----
// sample-clock phase alignment between the two converters
`timescale 1ns/1ps
`include "qti_map.svh"

module qti_phase_track #(
   parameter int DW          = 8,
   parameter int LOCK_CYCLES = `QTI_LOCK_CYCLES
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // control
   input  wire logic          auto_en,
   input  wire logic [DW-1:0] manual_delay,
   // phase detector
   input  wire logic          phase_lead,
   input  wire logic          phase_lag,
   // result
   output logic [DW-1:0]      delay_code,
   output logic               locked,
   output qti_pkg::qti_phase_e state
);
   import qti_pkg::*;

   localparam logic [DW-1:0] MID  = DW'(`QTI_DELAY_MID);
   localparam logic [DW-1:0] TOP  = {DW{1'b1}};
   localparam logic [7:0]    LOCK = 8'(LOCK_CYCLES - 1);

   logic [7:0] stable;
   logic       err;

   assign err = phase_lead ^ phase_lag;

   // -----------------------------------------------------------
   // mode state
   // -----------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= QTI_PH_MANUAL;
      else if (!auto_en)
         state <= QTI_PH_MANUAL;
      else
         unique case (state)
            QTI_PH_MANUAL:  state <= QTI_PH_ACQUIRE;
            QTI_PH_ACQUIRE: if (!err && stable == LOCK) state <= QTI_PH_LOCKED;
            QTI_PH_LOCKED:  if (err) state <= QTI_PH_ACQUIRE;
         endcase
   end

   // -----------------------------------------------------------
   // delay: manual value, or detector-driven steps toward 180 deg
   // -----------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         delay_code <= '0;
      else if (!auto_en)
         delay_code <= manual_delay;
      else if (state == QTI_PH_MANUAL)
         delay_code <= MID;
      else if (phase_lag && delay_code != '0)
         delay_code <= delay_code - 1'b1;
      else if (phase_lead && delay_code != TOP)
         delay_code <= delay_code + 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         stable <= '0;
      else if (!auto_en || err)
         stable <= '0;
      else if (stable != LOCK)
         stable <= stable + 8'h01;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         locked <= 1'b0;
      else
         locked <= auto_en && state == QTI_PH_ACQUIRE && !err && stable == LOCK;
   end

endmodule : qti_phase_track

// ---- logic/qti_trim_interleave_regs.sv ----
// second-channel trim and interleave control register bank
`timescale 1ns/1ps
`include "qti_map.svh"

module q_trim_interleave_regs #(
   parameter int DW          = 8,
   parameter int LOCK_CYCLES = `QTI_LOCK_CYCLES
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // register port
   input  wire logic [3:0]    reg_addr,
   input  wire logic [15:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [15:0]        reg_rdata,
   // manual delay from the coarse and fine delay registers
   input  wire logic [DW-1:0] manual_delay,
   // phase detector
   input  wire logic          phase_lead,
   input  wire logic          phase_lag,
   // second-channel trim
   output qti_pkg::qti_offset_s ch2_offset,
   output logic signed [16:0] ch2_offset_uv,
   output logic [8:0]         ch2_fs_code,
   output logic [9:0]         ch2_fs_mv,
   // converter mode and sampling
   output qti_pkg::qti_mode_e mode,
   output logic               shared_input,
   output logic               sample_a,
   output logic               sample_b,
   output logic               manual_delay_active,
   output logic [DW-1:0]      ch2_clk_delay,
   output logic               phase_locked
);
   import qti_pkg::*;

   // ------------------------------------------------------------
   // port capture and decode
   // ------------------------------------------------------------
   qti_bus_s bus;

   logic wr_offset;
   logic wr_fullscale;
   logic wr_interleave;
   logic rd_status;
   logic pad_bad;

   assign bus.addr  = reg_addr;
   assign bus.wdata = reg_wdata;
   assign bus.wr    = reg_wr;
   assign bus.rd    = reg_rd;

   assign wr_offset     = bus.wr && bus.addr == `QTI_OFS_CH2_OFFSET;
   assign wr_fullscale  = bus.wr && bus.addr == `QTI_OFS_CH2_FULLSCALE;
   assign wr_interleave = bus.wr && bus.addr == `QTI_OFS_INTERLEAVE;
   assign rd_status     = bus.rd && bus.addr == `QTI_OFS_STATUS;

   // padding bits are ignored, but a zero there is reported
   always_comb
   begin
      pad_bad = 1'b0;
      if (wr_offset || wr_fullscale)
         pad_bad = (bus.wdata & `QTI_TRIM_PAD_MASK) != `QTI_TRIM_PAD_MASK;
      else if (wr_interleave)
         pad_bad = (bus.wdata & `QTI_IL_PAD_MASK) != `QTI_IL_PAD_MASK;
   end

   // ------------------------------------------------------------
   // stored register images
   // ------------------------------------------------------------
   logic [15:0] offset_reg;
   logic [15:0] fullscale_reg;
   logic [15:0] interleave_reg;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         offset_reg <= `QTI_RST_CH2_OFFSET;
      else if (wr_offset)
         offset_reg <= bus.wdata;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         fullscale_reg <= `QTI_RST_CH2_FULLSCALE;
      else if (wr_fullscale)
         fullscale_reg <= bus.wdata;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         interleave_reg <= `QTI_RST_INTERLEAVE;
      else if (wr_interleave)
         interleave_reg <= bus.wdata;
   end

   // ------------------------------------------------------------
   // field extraction
   // ------------------------------------------------------------
   logic [7:0] mag;
   logic       neg;
   logic [8:0] fs_field;
   logic       il_en;
   logic       auto_en;

   assign mag      = offset_reg[`QTI_OFS_MAG_HI:`QTI_OFS_MAG_LO];
   assign neg      = offset_reg[`QTI_OFS_SIGN_BIT];
   assign fs_field = fullscale_reg[`QTI_FS_HI:`QTI_FS_LO];
   assign il_en    = interleave_reg[`QTI_IL_ENABLE_BIT];
   assign auto_en  = interleave_reg[`QTI_IL_AUTO_BIT];

   // ------------------------------------------------------------
   // trim values in physical units
   // ------------------------------------------------------------
   // constant divisors only; the product stays below 2^24
   logic [23:0] off_prod;
   logic [15:0] off_uv;
   logic [17:0] fs_prod;
   logic [9:0]  fs_mv;

   always_comb
   begin
      off_prod = 24'(mag) * 24'(`QTI_OFFSET_FULL_UV);
      off_uv   = 16'(off_prod / 24'(`QTI_OFFSET_MAX_CODE));
      fs_prod  = 18'(fs_field) * 18'(`QTI_FS_SPAN_MV);
      fs_mv    = 10'(`QTI_FS_MIN_MV) + 10'(fs_prod / 18'(`QTI_FS_MAX_CODE));
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ch2_offset    <= '0;
         ch2_offset_uv <= '0;
      end
      else
      begin
         ch2_offset.magnitude <= mag;
         ch2_offset.negative  <= neg;
         ch2_offset_uv        <= neg ? -$signed({1'b0, off_uv})
                                     :  $signed({1'b0, off_uv});
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ch2_fs_code <= `QTI_RST_FS_CODE;
         ch2_fs_mv   <= `QTI_RST_FS_MV;
      end
      else
      begin
         ch2_fs_code <= fs_field;
         ch2_fs_mv   <= fs_mv;
      end
   end

   // ------------------------------------------------------------
   // converter mode and sample strobes
   // ------------------------------------------------------------
   // one core cycle stands for half a sample-clock period; the phase bit
   // stands for the clock edge, so interleave yields two per period
   logic edge_phase;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         edge_phase <= 1'b0;
      else if (!il_en)
         edge_phase <= 1'b0;
      else
         edge_phase <= ~edge_phase;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode         <= QTI_MODE_DUAL;
         shared_input <= 1'b0;
      end
      else if (il_en)
      begin
         mode         <= QTI_MODE_INTERLEAVE;
         shared_input <= 1'b1;
      end
      else
      begin
         mode         <= QTI_MODE_DUAL;
         shared_input <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sample_a <= 1'b0;
         sample_b <= 1'b0;
      end
      else if (il_en)
      begin
         sample_a <= ~edge_phase;
         sample_b <= edge_phase;
      end
      else
      begin
         sample_a <= 1'b1;
         sample_b <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // sample-clock phase alignment
   // ------------------------------------------------------------
   logic [DW-1:0] delay_code;
   logic          locked;
   qti_phase_e    ph_state;

   qti_phase_track #(
      .DW          (DW),
      .LOCK_CYCLES (LOCK_CYCLES)
   ) u_phase (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .auto_en      (auto_en),
      .manual_delay (manual_delay),
      .phase_lead   (phase_lead),
      .phase_lag    (phase_lag),
      .delay_code   (delay_code),
      .locked       (locked),
      .state        (ph_state)
   );

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         manual_delay_active <= 1'b1;
         ch2_clk_delay       <= '0;
      end
      else
      begin
         manual_delay_active <= !auto_en;
         ch2_clk_delay       <= delay_code;
      end
   end

   // lock is held until the detector reports an error again or automatic phase is switched off
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         phase_locked <= 1'b0;
      else if (!auto_en)
         phase_locked <= 1'b0;
      else if (locked)
         phase_locked <= 1'b1;
      else if (ph_state != QTI_PH_LOCKED)
         phase_locked <= 1'b0;
   end

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   // set wins over clear-on-read so a bad write is never missed
   logic pad_error;
   logic fs_wide;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pad_error <= 1'b0;
      else if (pad_bad)
         pad_error <= 1'b1;
      else if (rd_status)
         pad_error <= 1'b0;
   end

   // advisory only: trim outside the recommended band still applies
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         fs_wide <= 1'b0;
      else
         fs_wide <= fs_field < `QTI_FS_REC_LO || fs_field > `QTI_FS_REC_HI;
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   // trim registers are write-only and read back as zero
   logic [15:0] next_rdata;

   always_comb
   begin
      next_rdata = 16'h0000;
      if (rd_status)
      begin
         next_rdata[`QTI_ST_INTERLEAVE] = il_en;
         next_rdata[`QTI_ST_AUTO_PHASE] = auto_en;
         next_rdata[`QTI_ST_LOCKED]     = phase_locked;
         next_rdata[`QTI_ST_PAD_ERROR]  = pad_error;
         next_rdata[`QTI_ST_FS_WIDE]    = fs_wide;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else
         reg_rdata <= next_rdata;
   end

endmodule : q_trim_interleave_regs

// ---- bench/q_trim_interleave_regs_sva.sv ----
// assertions on the ports of the trim and interleave register bank
`timescale 1ns/1ps

module q_trim_interleave_regs_sva
   import qti_pkg::*;
#(
   parameter int DW          = 8,
   parameter int LOCK_CYCLES = 16
) (
   // clock and reset
   input wire logic          core_clk,
   input wire logic          rst_n,
   // register port
   input wire logic [3:0]    reg_addr,
   input wire logic [15:0]   reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [15:0]   reg_rdata,
   input wire logic [DW-1:0] manual_delay,
   // trim and mode outputs
   input wire qti_offset_s   ch2_offset,
   input wire logic signed [16:0] ch2_offset_uv,
   input wire logic [8:0]    ch2_fs_code,
   input wire logic [9:0]    ch2_fs_mv,
   input wire qti_mode_e     mode,
   input wire logic          shared_input,
   input wire logic          sample_a,
   input wire logic          sample_b,
   input wire logic          manual_delay_active,
   input wire logic [DW-1:0] ch2_clk_delay
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_wr_ofs; reg_wr && reg_addr == 4'ha; endsequence
   sequence s_wr_fs;  reg_wr && reg_addr == 4'hb; endsequence
   sequence s_wr_il;  reg_wr && reg_addr == 4'hd; endsequence

   chk_offset_load: assert property (
      s_wr_ofs |-> ##2 ch2_offset == $past(reg_wdata[15:7], 2))
      else $error("offset fields not loaded");
   chk_offset_scale: assert property (
      ch2_offset_uv == (ch2_offset.negative ? -(int'(ch2_offset.magnitude) * 45000 / 255)
                        : int'(ch2_offset.magnitude) * 45000 / 255))
      else $error("offset microvolts wrong");
   chk_fs_load: assert property (
      s_wr_fs |-> ##2 ch2_fs_code == $past(reg_wdata[15:7], 2))
      else $error("full-scale code not loaded");
   chk_fs_scale: assert property (
      ch2_fs_mv == 10'(560 + int'(ch2_fs_code) * 280 / 511))
      else $error("full-scale millivolts wrong");
   chk_mode_follow: assert property (
      s_wr_il |-> ##2 mode == ($past(reg_wdata[15], 2) ? QTI_MODE_INTERLEAVE : QTI_MODE_DUAL)
      && shared_input == $past(reg_wdata[15], 2))
      else $error("mode does not follow write");
   chk_interleave_alt: assert property (
      shared_input && $past(shared_input) |-> (sample_a ^ sample_b) && $changed(sample_a))
      else $error("strobes not alternating");
   chk_dual_strobes: assert property (
      mode == QTI_MODE_DUAL && $past(mode) == QTI_MODE_DUAL && $past(rst_n)
      |-> sample_a && sample_b)
      else $error("dual strobes missing");
   chk_manual_select: assert property (
      s_wr_il |-> ##2 manual_delay_active == !$past(reg_wdata[14], 2))
      else $error("manual path select wrong");
   chk_manual_delay: assert property (
      manual_delay_active [*3] ##0 $past(rst_n, 2) |-> ch2_clk_delay == $past(manual_delay, 2))
      else $error("manual delay not used");
   chk_write_only: assert property (
      !($past(reg_rd) && $past(reg_addr) == 4'h1) |-> reg_rdata == 16'h0000)
      else $error("read data not zero");
endmodule : q_trim_interleave_regs_sva

bind q_trim_interleave_regs q_trim_interleave_regs_sva #(.DW(DW), .LOCK_CYCLES(LOCK_CYCLES))
   u_sva (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
          .manual_delay, .ch2_offset, .ch2_offset_uv, .ch2_fs_code, .ch2_fs_mv, .mode,
          .shared_input, .sample_a, .sample_b, .manual_delay_active, .ch2_clk_delay);

// ---- bench/q_trim_interleave_regs_tb.sv ----
// self-checking bench for the trim and interleave register bank
`timescale 1ns/1ps

module q_trim_interleave_regs_tb;
   import qti_pkg::*;

   logic               core_clk     = 1'b0;
   logic               rst_n        = 1'b0;
   logic [3:0]         reg_addr     = 4'h0;
   logic [15:0]        reg_wdata    = 16'h0000;
   logic               reg_wr       = 1'b0;
   logic               reg_rd       = 1'b0;
   logic [7:0]         manual_delay = 8'h00;
   logic               phase_lead   = 1'b0;
   logic               phase_lag    = 1'b0;
   logic [15:0]        reg_rdata;
   qti_offset_s        ch2_offset;
   logic signed [16:0] ch2_offset_uv;
   logic [8:0]         ch2_fs_code;
   logic [9:0]         ch2_fs_mv;
   qti_mode_e          mode;
   logic               shared_input;
   logic               sample_a;
   logic               sample_b;
   logic               manual_delay_active;
   logic [7:0]         ch2_clk_delay;
   logic               phase_locked;
   int                 fail_count   = 0;
   int                 checks_done  = 0;
   int                 k;
   logic [15:0]        rv;
   logic [8:0]         code;
   logic [7:0]         mag;
   logic               sg;

   always #5 core_clk = ~core_clk;

   q_trim_interleave_regs #(.DW(8), .LOCK_CYCLES(4)) u_dut (
      .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .manual_delay, .phase_lead, .phase_lag, .ch2_offset, .ch2_offset_uv,
      .ch2_fs_code, .ch2_fs_mv, .mode, .shared_input, .sample_a, .sample_b,
      .manual_delay_active, .ch2_clk_delay, .phase_locked);

   // ------------------------------
   // helpers
   // ------------------------------
   function automatic int uv_exp(input logic [7:0] m, input logic n);
      return n ? -(int'(m) * 45000 / 255) : int'(m) * 45000 / 255;
   endfunction : uv_exp

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // write, then wait until the field outputs have landed
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask : rd

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   // ------------------------------
   // main sequence
   // ------------------------------
   initial
   begin
      void'($urandom(32'h760e));
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1;
      check("offset", 32'h0, 32'(ch2_offset));
      check("fs_code", 32'h100, 32'(ch2_fs_code));
      check("mode", 32'(QTI_MODE_DUAL), 32'(mode));
      check("manual", 32'h1, 32'(manual_delay_active));
      rd(4'h1);
      check("status", 32'h0, 32'(rv));
      for (k = 0; k < 8; k++)
      begin
         mag = (k == 0) ? 8'h00 : (k < 3) ? 8'hff : 8'($urandom);
         sg  = (k == 1) ? 1'b1 : (k < 3) ? 1'b0 : 1'($urandom);
         wr(4'ha, {mag, sg, 7'h7f});
         check("offset", 32'({mag, sg}), 32'(ch2_offset));
         check("offset_uv", uv_exp(mag, sg), 32'(ch2_offset_uv));
      end
      for (k = 0; k < 8; k++)
      begin
         code = (k == 0) ? 9'h000 : (k == 1) ? 9'h100 : (k == 2) ? 9'h1ff : 9'($urandom);
         wr(4'hb, {code, 7'h7f});
         check("fs_code", 32'(code), 32'(ch2_fs_code));
         check("fs_mv", 32'(560 + int'(code) * 280 / 511), 32'(ch2_fs_mv));
      end
      // interleave with manual delay, then automatic phase
      @(posedge core_clk);
      manual_delay <= 8'($urandom);
      wr(4'hd, 16'hbfff);
      check("mode", 32'(QTI_MODE_INTERLEAVE), 32'(mode));
      check("shared", 32'h1, 32'(shared_input));
      check("delay", 32'(manual_delay), 32'(ch2_clk_delay));
      for (k = 0; k < 4; k++)
      begin
         sg = sample_a;
         @(posedge core_clk);
         #1;
         check("alternate", 32'({~sg, sg}), 32'({sample_a, sample_b}));
      end
      wr(4'hd, 16'hffff);
      check("manual", 32'h0, 32'(manual_delay_active));
      @(posedge core_clk);
      phase_lag <= 1'b1;
      repeat (3) @(posedge core_clk);
      phase_lag    <= 1'b0;
      manual_delay <= ~manual_delay;
      repeat (3) @(posedge core_clk);
      #1;
      check("auto_delay", 32'h7d, 32'(ch2_clk_delay));
      k = 0;
      while (phase_locked !== 1'b1 && k < 40)
      begin
         @(posedge core_clk);
         #1;
         k++;
      end
      check("locked", 32'h1, 32'(phase_locked));
      rd(4'h1);
      check("status", 32'h7, 32'(rv[2:0]));
      // a lead error steps the delay up and drops the lock
      @(posedge core_clk);
      phase_lead <= 1'b1;
      repeat (2) @(posedge core_clk);
      phase_lead <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check("lead_delay", 32'h7f, 32'(ch2_clk_delay));
      check("lock_lost", 32'h0, 32'(phase_locked));
      wr(4'hd, 16'h3fff);
      check("mode", 32'(QTI_MODE_DUAL), 32'(mode));
      check("manual", 32'h1, 32'(manual_delay_active));
      repeat (2) @(posedge core_clk);
      #1;
      check("strobes", 32'h3, 32'({sample_a, sample_b}));
      // zero padding is flagged until status is read
      wr(4'hb, 16'h0000);
      rd(4'h1);
      check("pad_flag", 32'h3, 32'(rv[4:3]));
      rd(4'h1);
      check("pad_clear", 32'h2, 32'(rv[4:3]));
      // unmapped write ignored, write-only places read zero
      wr(4'h5, 16'hffff);
      check("fs_code", 32'h0, 32'(ch2_fs_code));
      for (k = 0; k < 4; k++)
      begin
         rd((k == 0) ? 4'ha : (k == 1) ? 4'hb : (k == 2) ? 4'hd : 4'h5);
         check("read_zero", 32'h0, 32'(rv));
      end
      stop_test();
   end
endmodule : q_trim_interleave_regs_tb
